// file: core/tfbs_cfg.svh
// Purpose: register map, field positions and reset values of the timer flag block
// Assumes: word-aligned registers, byte address is four times the index
// Notes:   the indices are the register numbers seen by software
`ifndef TFBS_CFG_SVH
`define TFBS_CFG_SVH
`define TFBS_IDX_CONTROL_B_REG      6'h05
`define TFBS_IDX_CHMODE     6'h06
`define TFBS_IDX_IRQ_ENABLE_CLEAR_REG   6'h08
`define TFBS_IDX_IRQ_ENABLE_SET_REG   6'h09
`define TFBS_IDX_INTFLAG    6'h0A
`define TFBS_IDX_STATUS     6'h0B
`define TFBS_BIT_OVF        0
`define TFBS_BIT_ERR        1
`define TFBS_BIT_MC0        4
`define TFBS_BIT_STOP       0
`define TFBS_BIT_BUFV0      4
`define TFBS_BIT_LOCK_UPDATE       1
`define TFBS_RST_STATUS     8'h01
`define TFBS_RST_INTEN      8'h00
`define TFBS_RST_FLAGS      8'h00
`define TFBS_RST_CONTROL_B_REG      8'h00
`define TFBS_RST_CHMODE     4'h0
`define TFBS_MAX_CH         4
`endif

// file: core/tfbs_pkg.sv
// Purpose: types shared by the timer flag block
// Assumes: at most four channels
// Notes:   the whole module state is one packed struct
package tfbs_pkg;
  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        irq;
    logic [7:0]  flags;
    logic [3:0]  pendMc;
    logic        pendOvf;
    logic        pendErr;
    logic [7:0]  inten;
    logic        lockUpdate;
    logic [3:0]  capMode;
    logic [3:0]  bufValid;
    logic        stopMeta;
    logic        stopSync;
    logic [7:0]  statusShadow;
  } tfbs_state_type;
endpackage

// file: core/tfbs_flags.sv
// Purpose: interrupt flags and buffer-valid status of a timer/counter, APB slave
// Assumes: events come from logic on mclk; cntTick is the counter clock enable
// Notes:   one wait state on every APB access; unmapped indices answer pslverr
//
// Summary of operation
// - channel flag sets on match or capture
// - flag sets next counter tick, enabled interrupt
// - write one clears channel flag, zero ignored
// - capture mode: value read clears channel flag
// - capture while channel flag set raises error
// - write one clears error flag
// - overflow flag next tick, enable via set/clear
// - write one clears overflow flag
// - status read synchronized, resets to 0x01
// - compare buffer write sets buffer valid
// - buffer valid clears by locked write, update
// - capture into buffer sets buffer valid
// - capture mode: value read clears buffer valid
//
// Added by the designer: register access over APB.
`timescale 1ns/100ps
`include "tfbs_cfg.svh"

module tfbs_flags #(
  parameter int NCH = 4
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        cntTick,
  input  wire logic [3:0]  cmpMatch,
  input  wire logic [3:0]  capEvent,
  input  wire logic        cntOverflow,
  input  wire logic        updateEvent,
  input  wire logic [3:0]  bufWrite,
  input  wire logic [3:0]  capBufLoad,
  input  wire logic [3:0]  ccRead,
  input  wire logic        counterStopped,
  output logic             irq
);

  initial
  begin
    if (NCH < 1 || NCH > `TFBS_MAX_CH)
      $error("NCH out of range");
  end

  tfbs_pkg::tfbs_state_type state_r;
  tfbs_pkg::tfbs_state_type state_nxt;

  localparam logic [3:0] CH_MASK = 4'((1 << NCH) - 1);

  // set wins over clear so no event is lost
  function automatic logic [7:0] setClear(
    input logic [7:0] cur,
    input logic [7:0] setBits,
    input logic [7:0] clrBits
  );
    setClear = (cur & ~clrBits) | setBits;
  endfunction

  logic        accDone;
  logic        accFirst;
  logic [5:0]  regIdx;
  logic        idxValid;
  logic        wrDone;
  logic [7:0]  wByte;
  logic [3:0]  mcEvt;
  logic [3:0]  capRead;
  logic [3:0]  overrun;
  logic [7:0]  flagSet;
  logic [7:0]  flagClr;
  logic [3:0]  bvSet;
  logic [3:0]  bvClr;
  logic [7:0]  bvNew;
  logic [31:0] rdMux;

  // apb phases; second access cycle completes the transfer
  assign accFirst = psel & penable & ~state_r.pready;
  assign accDone  = psel & penable & state_r.pready;
  assign regIdx   = paddr[7:2];
  assign wrDone   = accDone & pwrite & ~state_r.pslverr;
  assign wByte    = pwdata[7:0];

  // index decode
  always_comb
  begin
    unique case (regIdx)
      `TFBS_IDX_CONTROL_B_REG, `TFBS_IDX_CHMODE, `TFBS_IDX_IRQ_ENABLE_CLEAR_REG,
      `TFBS_IDX_IRQ_ENABLE_SET_REG, `TFBS_IDX_INTFLAG, `TFBS_IDX_STATUS:
        idxValid = 1'b1;
      default:
        idxValid = 1'b0;
    endcase
  end

  // read data; status comes from the synchronized shadow copy
  always_comb
  begin
    rdMux = 32'h0000_0000;
    unique case (regIdx)
      `TFBS_IDX_CONTROL_B_REG:
        rdMux[`TFBS_BIT_LOCK_UPDATE] = state_r.lockUpdate;
      `TFBS_IDX_CHMODE:
        rdMux[3:0] = state_r.capMode;
      `TFBS_IDX_IRQ_ENABLE_CLEAR_REG, `TFBS_IDX_IRQ_ENABLE_SET_REG:
        rdMux[7:0] = state_r.inten;
      `TFBS_IDX_INTFLAG:
        rdMux[7:0] = state_r.flags;
      `TFBS_IDX_STATUS:
        rdMux[7:0] = state_r.statusShadow;
      default:
        rdMux = 32'h0000_0000;
    endcase
  end

  // event qualification per channel
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      // capture channels flag on capture, compare channels on match
      mcEvt[i] = state_r.capMode[i] ? capEvent[i] : cmpMatch[i];
      capRead[i] = ccRead[i] & state_r.capMode[i];
      // no room left: flag still set or pending from last tick
      overrun[i] = state_r.capMode[i] & capEvent[i]
                   & (state_r.flags[`TFBS_BIT_MC0 + i] | state_r.pendMc[i]);
    end
    mcEvt   = mcEvt & CH_MASK;
    capRead = capRead & CH_MASK;
    overrun = overrun & CH_MASK;
  end

  // flag set and clear terms
  always_comb
  begin
    flagSet = 8'h00;
    flagClr = 8'h00;
    if (cntTick)
    begin
      // pending events land one counter tick after they occur
      flagSet[`TFBS_BIT_MC0 +: 4] = state_r.pendMc;
      flagSet[`TFBS_BIT_OVF] = state_r.pendOvf;
      flagSet[`TFBS_BIT_ERR] = state_r.pendErr;
    end
    if (wrDone && regIdx == `TFBS_IDX_INTFLAG)
    begin
      flagClr[`TFBS_BIT_MC0 +: 4] = wByte[`TFBS_BIT_MC0 +: 4] & CH_MASK;
      flagClr[`TFBS_BIT_ERR] = wByte[`TFBS_BIT_ERR];
      flagClr[`TFBS_BIT_OVF] = wByte[`TFBS_BIT_OVF];
    end
    flagClr[`TFBS_BIT_MC0 +: 4] = flagClr[`TFBS_BIT_MC0 +: 4] | capRead;
  end

  // buffer valid set and clear terms
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (state_r.capMode[i])
      begin
        bvSet[i] = capBufLoad[i];
        bvClr[i] = ccRead[i];
      end
      else
      begin
        bvSet[i] = bufWrite[i];
        // software clear only honoured while updates are locked
        bvClr[i] = updateEvent
                   | (wrDone && regIdx == `TFBS_IDX_STATUS && state_r.lockUpdate
                      && wByte[`TFBS_BIT_BUFV0 + i]);
      end
    end
    bvSet = bvSet & CH_MASK;
    bvClr = bvClr & CH_MASK;
    bvNew = setClear({state_r.bufValid, 4'h0}, {bvSet, 4'h0}, {bvClr, 4'h0});
  end

  // next state
  always_comb
  begin
    state_nxt = state_r;

    // apb answer: ready and data raised after the first access cycle
    state_nxt.pready  = accFirst;
    state_nxt.pslverr = accFirst & ~idxValid;
    state_nxt.prdata  = (accFirst && !pwrite && idxValid) ? rdMux : 32'h0000_0000;

    // hold events until the next tick, gather new ones on this tick
    if (cntTick)
    begin
      state_nxt.pendMc  = mcEvt;
      state_nxt.pendOvf = cntOverflow;
      state_nxt.pendErr = |overrun;
    end
    else
    begin
      state_nxt.pendMc  = state_r.pendMc | mcEvt;
      state_nxt.pendOvf = state_r.pendOvf | cntOverflow;
      state_nxt.pendErr = state_r.pendErr | (|overrun);
    end

    state_nxt.flags    = setClear(state_r.flags, flagSet, flagClr);
    state_nxt.bufValid = bvNew[7:4];

    // register writes
    if (wrDone)
    begin
      unique case (regIdx)
        `TFBS_IDX_CONTROL_B_REG:
          state_nxt.lockUpdate = wByte[`TFBS_BIT_LOCK_UPDATE];
        `TFBS_IDX_CHMODE:
          state_nxt.capMode = wByte[3:0] & CH_MASK;
        `TFBS_IDX_IRQ_ENABLE_CLEAR_REG:
          state_nxt.inten = state_r.inten & ~wByte;
        `TFBS_IDX_IRQ_ENABLE_SET_REG:
          state_nxt.inten = state_r.inten | wByte;
        default:
          state_nxt.inten = state_r.inten;
      endcase
    end

    // stopped indication crosses in through two flops
    state_nxt.stopMeta = counterStopped;
    state_nxt.stopSync = state_r.stopMeta;

    // shadow copy gives a coherent status read
    state_nxt.statusShadow = {state_r.bufValid, 3'b000, state_r.stopSync};

    // level interrupt from enabled flags; registered in the same cycle as the flags
    state_nxt.irq = |(state_nxt.flags & state_r.inten);
  end

  // single state register, synchronous reset
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      state_r              <= '0;
      state_r.flags        <= `TFBS_RST_FLAGS;
      state_r.inten        <= `TFBS_RST_INTEN;
      // only the lock bit of the control reset value is kept here
      state_r.lockUpdate   <= 1'(`TFBS_RST_CONTROL_B_REG >> `TFBS_BIT_LOCK_UPDATE);
      state_r.capMode      <= `TFBS_RST_CHMODE;
      state_r.stopMeta     <= 1'b1;
      state_r.stopSync     <= 1'b1;
      state_r.statusShadow <= `TFBS_RST_STATUS;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign pready  = state_r.pready;
  assign prdata  = state_r.prdata;
  assign pslverr = state_r.pslverr;
  assign irq     = state_r.irq;

endmodule

// file: test/tfbs_flags_chk.sv
// Purpose: bus timing and reply checks of the timer flag block
// Assumes: one wait state on every access, set by the designer
// Notes:   sees only the top ports; bound at the foot of this file
`timescale 1ns/100ps
module tfbs_flags_chk (
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        irq
);
  logic mapped;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // decoded register indices, anything else must be refused
  assign mapped = paddr[7:2] inside {6'h05, 6'h06, 6'h08, 6'h09, 6'h0A, 6'h0B};
  // access phase answered after exactly one wait state
  acc_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("ready not one cycle after access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_sel_a: assert property (pready |-> psel && penable)
    else $error("ready outside a transfer");
  err_qual_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  // read data only in the answer cycle of a read, upper bits unused
  rdata_idle_a: assert property ((!pready || pwrite) |-> prdata == 32'h0)
    else $error("read data outside read answer");
  rdata_upper_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  unmap_err_a: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped access not refused");
  map_ok_a: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access refused");
  irq_reset_a: assert property ($rose(nrst) |-> !irq)
    else $error("interrupt high out of reset");
endmodule
bind tfbs_flags tfbs_flags_chk chk_u (.mclk(mclk), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .irq(irq));

// file: test/tfbs_flags_test.sv
// Purpose: self-checking bench of the timer flag block
// Assumes: byte address is four times the register index
// Notes:   events pass through a pending stage and a counter tick
`timescale 1ns/100ps
module tfbs_flags_test;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cntTick = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, irq, cntOverflow = 1'b0, updateEvent = 1'b0;
  logic [3:0]  cmpMatch = 4'h0, capEvent = 4'h0, bufWrite = 4'h0;
  logic [3:0]  capBufLoad = 4'h0, ccRead = 4'h0;
  logic        counterStopped = 1'b1;
  int          n_fail = 0, num_checks = 0;
  tfbs_flags #(.NCH(4)) dut_u (.mclk(mclk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .cntTick(cntTick),
    .cmpMatch(cmpMatch), .capEvent(capEvent), .cntOverflow(cntOverflow),
    .updateEvent(updateEvent), .bufWrite(bufWrite), .capBufLoad(capBufLoad),
    .ccRead(ccRead), .counterStopped(counterStopped), .irq(irq));
  // 40 MHz clock
  always #12.5 mclk = ~mclk;
  task finish_test;
    if (n_fail == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one transfer; request held until ready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    t = 0;
    @(posedge mclk);
    while (pready !== 1'b1 && t < 20)
    begin
      t++;
      @(posedge mclk);
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // a slave that never answers ends the run as a failure
    if (t == 20)
    begin
      n_fail++;
      finish_test;
    end
  endtask
  // status is a delayed shadow, so give it time before reading
  task rdc(input logic [7:0] a, input logic [31:0] e);
    repeat (3) @(posedge mclk);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // event pulses, then a counter tick one cycle later
  task evt(input logic [3:0] m, c, b, l, r, input logic o, u);
    @(posedge mclk);
    cmpMatch <= m; capEvent <= c; bufWrite <= b; capBufLoad <= l;
    ccRead <= r; cntOverflow <= o; updateEvent <= u;
    @(posedge mclk);
    {cmpMatch, capEvent, bufWrite, capBufLoad, ccRead} <= 20'h0;
    cntOverflow <= 1'b0; updateEvent <= 1'b0; cntTick <= 1'b1;
    @(posedge mclk) cntTick <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  task t_reset;
    rdc(8'h2C, 32'h01);
    rdc(8'h28, 32'h00);
    apb(1'b1, 8'h00, 32'hFF);
    rdc(8'h00, 32'h00);
  endtask
  task t_match;
    apb(1'b1, 8'h24, 32'hF3);
    rdc(8'h20, 32'hF3);
    evt(4'h1, 4'h0, 4'h0, 4'h0, 4'h0, 1'b0, 1'b0);
    rdc(8'h28, 32'h10);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 8'h28, 32'h00);
    rdc(8'h28, 32'h10);
    apb(1'b1, 8'h28, 32'h10);
    rdc(8'h28, 32'h00);
    chk({31'h0, irq}, 32'h0);
    evt(4'hF, 4'h0, 4'h0, 4'h0, 4'h0, 1'b0, 1'b0);
    rdc(8'h28, 32'hF0);
    apb(1'b1, 8'h28, 32'hF0);
  endtask
  task t_ovf;
    apb(1'b1, 8'h20, 32'h01);
    rdc(8'h24, 32'hF2);
    evt(4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 1'b1, 1'b0);
    rdc(8'h28, 32'h01);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 8'h28, 32'h01);
    rdc(8'h28, 32'h00);
  endtask
  task t_cap;
    apb(1'b1, 8'h18, 32'h01);
    evt(4'h0, 4'h1, 4'h0, 4'h0, 4'h0, 1'b0, 1'b0);
    rdc(8'h28, 32'h10);
    evt(4'h0, 4'h1, 4'h0, 4'h0, 4'h0, 1'b0, 1'b0);
    rdc(8'h28, 32'h12);
    evt(4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 1'b0, 1'b0);
    rdc(8'h28, 32'h02);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 8'h28, 32'h02);
    rdc(8'h28, 32'h00);
  endtask
  task t_buf;
    counterStopped <= 1'b0;
    evt(4'h0, 4'h0, 4'h2, 4'h0, 4'h0, 1'b0, 1'b0);
    rdc(8'h2C, 32'h20);
    evt(4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 1'b0, 1'b1);
    rdc(8'h2C, 32'h00);
    evt(4'h0, 4'h0, 4'h2, 4'h0, 4'h0, 1'b0, 1'b0);
    apb(1'b1, 8'h2C, 32'h20);
    rdc(8'h2C, 32'h20);
    apb(1'b1, 8'h14, 32'h02);
    apb(1'b1, 8'h2C, 32'h20);
    rdc(8'h2C, 32'h00);
    evt(4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 1'b0, 1'b0);
    rdc(8'h2C, 32'h10);
    evt(4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 1'b0, 1'b0);
    rdc(8'h2C, 32'h00);
  endtask
  // reset for two cycles, then the scenarios in turn
  initial
  begin
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    t_reset;
    t_match;
    t_ovf;
    t_cap;
    t_buf;
    finish_test;
  end
  // watchdog, far beyond the few hundred cycles the run needs
  initial
  begin
    #100us;
    n_fail++;
    finish_test;
  end
endmodule
